/* File: bench/tcc_channels_sva.sv */
`timescale 1ns/1ps
module tcc_channels_sva #(
    parameter NCH = 2
) (
    input wire logic           clk,
    input wire logic           rst,
    input wire logic           wb_cyc_i,
    input wire logic           wb_stb_i,
    input wire logic           wb_we_i,
    input wire logic [7:0]     wb_adr_i,
    input wire logic [3:0]     wb_sel_i,
    input wire logic [31:0]    wb_dat_i,
    input wire logic [31:0]    wb_dat_o,
    input wire logic           wb_ack_o,
    input wire logic [15:0]    cnt_val,
    input wire logic           cnt_tick,
    input wire logic           cnt_down,
    input wire logic           cnt_ovf,
    input wire logic [NCH-1:0] chan_in,
    input wire logic [NCH-1:0] chan_out,
    input wire logic [NCH-1:0] chan_oe,
    input wire logic [15:0]    mod_value,
    input wire logic           center_align_select,
    input wire logic           ovf_irq,
    input wire logic [NCH-1:0] chan_irq
);
    wire wr;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // a write reaches the request outputs two edges late, so quiet means two idle cycles
    sequence s_quiet;
        !wr && !$past(wr);
    endsequence
    property p_ack;
        s_take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_ovf_hold;
        s_quiet and ovf_irq |=> ovf_irq;
    endproperty
    property p_chan_hold;
        s_quiet |=> ((chan_irq & $past(chan_irq)) == $past(chan_irq));
    endproperty
    property p_ovf_rise;
        $rose(ovf_irq) |-> $past(cnt_ovf) || $past(cnt_ovf, 2) || $past(wr);
    endproperty
    property p_mod_up;
        !center_align_select && !$past(center_align_select) && $changed(mod_value)
            |-> $past(wr);
    endproperty
    property p_mod_center;
        center_align_select && $past(center_align_select) && $changed(mod_value)
            |-> $past(cnt_ovf) || $past(cnt_ovf, 2);
    endproperty
    property p_oe;
        $changed(chan_oe) |-> $past(wr);
    endproperty
    property p_out;
        $changed(chan_out) |-> $past(cnt_tick || cnt_ovf || wr);
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus access not answered for exactly one cycle");
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow request dropped without a write");
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel request dropped without a write");
    a_ovf_rise: assert property (p_ovf_rise)
        else $error("overflow request raised without overflow");
    a_mod_up: assert property (p_mod_up)
        else $error("modulus changed without a write");
    a_mod_center: assert property (p_mod_center)
        else $error("center modulus changed away from reversal");
    a_oe: assert property (p_oe)
        else $error("pin enable changed without a write");
    a_out: assert property (p_out)
        else $error("pin level changed without a cause");
endmodule // tcc_channels_sva

/* File: bench/tcc_channels_tb.sv */
`timescale 1ns/1ps
`define TCC_CHK(nm, e, a) begin tests_run = tests_run + 1; if ((a) !== (e)) begin \
    mismatches = mismatches + 1; $display("wrong value %s expected %h seen %h", nm, e, a); end end
module tcc_channels_tb;
    localparam NCH = 2;
    logic           clk, rst, cyc, stb, we, ack, tick, down, ovf, csel, ovf_irq;
    logic [7:0]     adr, q;
    logic [3:0]     sel;
    logic [31:0]    dat_w, dat_r;
    logic [15:0]    cnt, mod_value, r, rv;
    logic [NCH-1:0] pins, chan_in, chan_out, chan_oe, chan_irq;
    integer         mismatches = 0, tests_run = 0, seed = 32'hED87F4C2, eo, v, i;

    tcc_channels #(.NCH(NCH)) tcc_channels_inst (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .cnt_val(cnt), .cnt_tick(tick), .cnt_down(down),
        .cnt_ovf(ovf), .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe),
        .mod_value(mod_value), .center_align_select(csel), .ovf_irq(ovf_irq),
        .chan_irq(chan_irq));
    tcc_pin_model #(.NCH(NCH)) tcc_pin_model_inst (.drive_lvl(pins), .chan_out(chan_out),
        .chan_oe(chan_oe), .chan_in(chan_in));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // request held until ack is sampled high, then released for at least one cycle
    task bus(input [7:0] a, input w, input [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel} <= {2'b11, w, a, 4'hF};
        dat_w <= {24'h000000, d};
        // no cycle count assumed: only the watchdog ends a hung wait
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = dat_r[7:0];
        {cyc, stb, we} <= 3'b000;
    endtask
    task wr16(input [7:0] b, input [15:0] d);
        bus(b + 8'h04, 1'b1, d[15:8]);
        bus(b + 8'h08, 1'b1, d[7:0]);
    endtask
    task rd16(input [7:0] b);
        bus(b + 8'h04, 1'b0, 8'h00);
        rv[15:8] = q;
        bus(b + 8'h08, 1'b0, 8'h00);
        rv[7:0] = q;
    endtask
    task step(input [15:0] c, input o);
        @(posedge clk);
        {cnt, tick, ovf} <= {c, 1'b1, o};
        @(posedge clk);
        {tick, ovf} <= 2'b00;
        @(negedge clk);
    endtask
    task edge1(input [15:0] c);
        @(posedge clk);
        {cnt, pins[1]} <= {c, 1'b1};
        repeat (3) @(posedge clk);
        {cnt, pins[1]} <= {~c, 1'b0};
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {rst, cyc, stb, we, adr, sel, dat_w, cnt, tick, down, ovf, pins} = 0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(8'h00, 1'b0, 8'h00);
        `TCC_CHK("module_control", 8'h00, q)
        bus(8'hF0, 1'b1, 8'hFF);
        bus(8'hF0, 1'b0, 8'h00);
        `TCC_CHK("unmapped", 8'h00, q)
        $display("done reset and map");
        bus(8'h10, 1'b1, 8'h54);
        bus(8'h14, 1'b1, 8'h12);
        bus(8'h10, 1'b1, 8'h54);
        bus(8'h18, 1'b1, 8'h34);
        rd16(8'h10);
        `TCC_CHK("half value", 16'h0000, rv)
        bus(8'h14, 1'b1, 8'h12);
        rd16(8'h10);
        `TCC_CHK("paired value", 16'h1234, rv)
        eo = 0;
        for (i = 0; i < 3; i = i + 1) begin
            if (i == 2)
                bus(8'h10, 1'b0, 8'h00);
            step(16'h1234, 1'b0);
            eo = !eo;
            `TCC_CHK("compare pin", eo[0], chan_out[0])
            if (i == 0) begin
                bus(8'h10, 1'b0, 8'h00);
                `TCC_CHK("flag set", 8'hD4, q)
                `TCC_CHK("chan irq", 1'b1, chan_irq[0])
                bus(8'h10, 1'b1, 8'h54);
                bus(8'h10, 1'b0, 8'h00);
                `TCC_CHK("flag cleared", 8'h54, q)
                `TCC_CHK("chan irq off", 1'b0, chan_irq[0])
            end
        end
        bus(8'h10, 1'b1, 8'h54);
        bus(8'h10, 1'b0, 8'h00);
        `TCC_CHK("flag kept", 8'hD4, q)
        $display("done compare and flags");
        bus(8'h20, 1'b1, 8'h04);
        for (i = 0; i < 3; i = i + 1) begin
            r = $random(seed);
            edge1(r);
            rd16(8'h20);
            `TCC_CHK("capture", r, rv)
        end
        bus(8'h20, 1'b0, 8'h00);
        `TCC_CHK("capture flag", 1'b1, q[7])
        bus(8'h24, 1'b0, 8'h00);
        edge1(16'hA5C3);
        bus(8'h28, 1'b0, 8'h00);
        `TCC_CHK("frozen low", r[7:0], q)
        rd16(8'h20);
        `TCC_CHK("recapture", 16'hA5C3, rv)
        $display("done capture");
        wr16(8'h00, 16'h0010);
        @(negedge clk);
        `TCC_CHK("modulus", 16'h0010, mod_value)
        bus(8'h10, 1'b1, 8'h28);
        for (i = 0; i < 3; i = i + 1) begin
            v = (i == 0) ? 8 : (i == 1) ? 0 : 32;
            wr16(8'h10, v[15:0]);
            @(posedge clk);
            cnt <= 16'h0000;
            step(16'h0000, 1'b1);
            `TCC_CHK("pwm at wrap", v != 0, chan_out[0])
            step(16'h0008, 1'b0);
            `TCC_CHK("pwm at match", v > 16, chan_out[0])
        end
        $display("done edge pwm");
        bus(8'h00, 1'b1, 8'h60);
        wr16(8'h00, 16'h0020);
        `TCC_CHK("center buffered", 16'h0010, mod_value)
        `TCC_CHK("ovf irq", 1'b1, ovf_irq)
        step(16'h0010, 1'b1);
        `TCC_CHK("center full duty", 1'b1, chan_out[0])
        `TCC_CHK("center zero duty", 1'b1, chan_out[1])
        @(negedge clk);
        `TCC_CHK("center reload", 16'h0020, mod_value)
        bus(8'h04, 1'b1, 8'h00);
        bus(8'h00, 1'b1, 8'h20);
        bus(8'h08, 1'b1, 8'h30);
        step(16'h0020, 1'b1);
        `TCC_CHK("center up match", 1'b0, chan_out[0])
        @(negedge clk);
        `TCC_CHK("discarded", 16'h0020, mod_value)
        `TCC_CHK("center select", 1'b1, csel)
        `TCC_CHK("ovf irq off", 1'b0, ovf_irq)
        @(posedge clk);
        down <= 1'b1;
        step(16'h0020, 1'b0);
        `TCC_CHK("center down match", 1'b1, chan_out[0])
        $display("done center pwm");
        summarize;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches = mismatches + 1;
        summarize;
    end
endmodule // tcc_channels_tb
bind tcc_channels tcc_channels_sva #(.NCH(NCH)) tcc_channels_sva_inst (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cnt_val(cnt_val), .cnt_tick(cnt_tick), .cnt_down(cnt_down), .cnt_ovf(cnt_ovf),
    .chan_in(chan_in), .chan_out(chan_out), .chan_oe(chan_oe), .mod_value(mod_value),
    .center_align_select(center_align_select), .ovf_irq(ovf_irq), .chan_irq(chan_irq));

/* File: bench/tcc_pin_model.sv */
`timescale 1ns/1ps
module tcc_pin_model #(
    parameter NCH = 2
) (
    input  wire logic [NCH-1:0] drive_lvl,
    input  wire logic [NCH-1:0] chan_out,
    input  wire logic [NCH-1:0] chan_oe,
    output logic      [NCH-1:0] chan_in
);
    // a driven pin reads back its own level, a released one shows the event source
    always_comb chan_in = (chan_oe & chan_out) | (~chan_oe & drive_lvl);
endmodule // tcc_pin_model

/* File: common/tcc_consts.vh */
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH
// ----------------------------------------------------------------------
// register map (byte addresses, one 32-bit word each, data in bits 7:0)
// ----------------------------------------------------------------------
`define TCC_OFS_MCTRL    8'h00
`define TCC_OFS_MOD_HI   8'h04
`define TCC_OFS_MOD_LO   8'h08
`define TCC_OFS_CH_CTRL  4'h0
`define TCC_OFS_CH_VHI   4'h4
`define TCC_OFS_CH_VLO   4'h8
`define TCC_CH_PAGE0     4'h1
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TCC_BIT_FLAG     7
`define TCC_BIT_IE       6
`define TCC_BIT_CENTER_ALIGN_SELECT    5
`define TCC_BIT_MSB      5
`define TCC_BIT_MSA      4
`define TCC_BIT_ELSB     3
`define TCC_BIT_ELSA     2
`define TCC_MISC_HI      4
`define TCC_MISC_LO      0
// ----------------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------------
`define TCC_MS_CAPTURE   2'b00
`define TCC_MS_COMPARE   2'b01
`define TCC_ELS_OFF      2'b00
`define TCC_ELS_TOGGLE   2'b01
`define TCC_ELS_CLEAR    2'b10
`define TCC_ELS_SET      2'b11
`define TCC_RST_BYTE     8'h00
`define TCC_RST_MISC     5'h00
`define TCC_RST_WORD     16'h0000
`define TCC_ZERO_WORD    16'h0000
`define TCC_RD_PAD       24'h000000
`endif

/* File: hdl/tcc_channels.v */
`timescale 1ns/1ps
// Functional notes
// - with center select 0, mode bits pick capture, compare or edge pwm
// - capture copies counter value into channel value on selected pin edge
// - reading either value byte freezes both; control write resets read sequence
// - every recognised capture edge sets the channel event flag
// - compare match sets, clears or toggles pin and sets event flag
// - compare value loads only after both bytes; control write restarts pairing
// - edge pwm uses up counter, modulus sets period, channel value duty
// - edge pwm: overflow drives active, match drives inactive, polarity swaps them
// - edge pwm: value 0000 gives 0 percent, above modulus 100 percent
// - edge pwm value buffered, loaded after both bytes and counter at 0000
// - center pwm: counter up to modulus then down, duty from channel value
// - center pwm: zero or bit 15 value 0 percent, above nonzero modulus 100 percent
// - center pwm: up match inactive, down match active, polarity selects sense
// - center pwm modulus and values buffered, loaded together at reversal
// - module control write drops modulus bytes; channel control drops value bytes
// - compare and pwm set event flag on every counter match
// - interrupt request asserted while enable set and its flag is 1
// - flag clears by read seeing 1 then write 0; new event keeps it set
// - overflow flag set on counter wrap or on center-mode turn-down
`include "tcc_consts.vh"

module tcc_channels #(
    parameter NCH = 2
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [7:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    input  wire [15:0]      cnt_val,
    input  wire             cnt_tick,
    input  wire             cnt_down,
    input  wire             cnt_ovf,
    input  wire [NCH-1:0]   chan_in,
    output wire [NCH-1:0]   chan_out,
    output wire [NCH-1:0]   chan_oe,
    output reg  [15:0]      mod_value,
    output reg              center_align_select,
    output reg              ovf_irq,
    output wire [NCH-1:0]   chan_irq
);

// ----------------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------------
    // one access per cycle pair: ack drops the cycle after it rises
    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = req & wb_we_i & wb_sel_i[0];
    wire        rd      = req & ~wb_we_i;
    wire [7:0]  wdat    = wb_dat_i[7:0];
    wire        mctrl_a = (wb_adr_i == `TCC_OFS_MCTRL);
    wire        modhi_a = (wb_adr_i == `TCC_OFS_MOD_HI);
    wire        modlo_a = (wb_adr_i == `TCC_OFS_MOD_LO);

    function ch_hit;
        input [7:0] adr;
        input integer n;
        begin
            ch_hit = (adr[7:4] == `TCC_CH_PAGE0 + n[3:0]);
        end
    endfunction

    function [7:0] byte_sel;
        input [15:0] w;
        input        hi;
        begin
            byte_sel = hi ? w[15:8] : w[7:0];
        end
    endfunction

// ----------------------------------------------------------------------
// module control, overflow flag and modulus
// ----------------------------------------------------------------------
    reg         ovf_flag_reg;
    reg         ovf_arm_reg;
    reg         ovf_ie_reg;
    reg  [4:0]  misc_reg;
    reg  [15:0] mod_buf_reg;
    reg         mod_hi_seen_reg;
    reg         mod_lo_seen_reg;

    wire mod_paired = mod_hi_seen_reg & mod_lo_seen_reg;
    // outside center mode the modulus goes straight to the counter
    wire mod_load = mod_paired & (~center_align_select | cnt_ovf);

    always @(posedge clk)
    begin
        if (rst)
        begin
            ovf_flag_reg        <= 1'b0;
            ovf_arm_reg         <= 1'b0;
            ovf_ie_reg          <= 1'b0;
            center_align_select <= 1'b0;
            misc_reg            <= `TCC_RST_MISC;
            mod_buf_reg         <= `TCC_RST_WORD;
            mod_value           <= `TCC_RST_WORD;
            mod_hi_seen_reg     <= 1'b0;
            mod_lo_seen_reg     <= 1'b0;
            ovf_irq             <= 1'b0;
        end
        else
        begin
            if (cnt_ovf)
            begin
                ovf_flag_reg <= 1'b1;
                ovf_arm_reg  <= 1'b0;
            end
            else if (wr && mctrl_a && !wdat[`TCC_BIT_FLAG] && ovf_arm_reg)
            begin
                ovf_flag_reg <= 1'b0;
                ovf_arm_reg  <= 1'b0;
            end
            else if (rd && mctrl_a && ovf_flag_reg)
                ovf_arm_reg <= 1'b1;
            if (wr && mctrl_a)
            begin
                ovf_ie_reg          <= wdat[`TCC_BIT_IE];
                center_align_select <= wdat[`TCC_BIT_CENTER_ALIGN_SELECT];
                misc_reg            <= wdat[`TCC_MISC_HI:`TCC_MISC_LO];
                mod_hi_seen_reg     <= 1'b0;
                mod_lo_seen_reg     <= 1'b0;
            end
            else if (mod_load)
            begin
                mod_value       <= mod_buf_reg;
                mod_hi_seen_reg <= 1'b0;
                mod_lo_seen_reg <= 1'b0;
            end
            else if (wr && modhi_a)
            begin
                mod_buf_reg[15:8] <= wdat;
                mod_hi_seen_reg   <= 1'b1;
            end
            else if (wr && modlo_a)
            begin
                mod_buf_reg[7:0] <= wdat;
                mod_lo_seen_reg  <= 1'b1;
            end
            ovf_irq <= ovf_flag_reg & ovf_ie_reg;
        end
    end

// ----------------------------------------------------------------------
// channels
// ----------------------------------------------------------------------
    wire [8*NCH-1:0] ch_rd_flat;

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : ch
            reg         flag_reg;
            reg         arm_reg;
            reg         ie_reg;
            reg  [1:0]  ms_reg;
            reg  [1:0]  els_reg;
            reg  [15:0] val_reg;
            reg  [15:0] buf_reg;
            reg         hi_seen_reg;
            reg         lo_seen_reg;
            reg  [15:0] snap_reg;
            reg         rlat_reg;
            reg         rfirst_hi_reg;
            reg         pin_prev_reg;
            reg         out_reg;
            reg         oe_reg;
            reg         irq_reg;
            reg         out_next;

            wire hit     = ch_hit(wb_adr_i, g);
            wire ctrl_a  = hit & (wb_adr_i[3:0] == `TCC_OFS_CH_CTRL);
            wire vhi_a   = hit & (wb_adr_i[3:0] == `TCC_OFS_CH_VHI);
            wire vlo_a   = hit & (wb_adr_i[3:0] == `TCC_OFS_CH_VLO);
            wire ctrl_wr = wr & ctrl_a;

            wire m_cap = ~center_align_select & (ms_reg == `TCC_MS_CAPTURE);
            wire m_cmp = ~center_align_select & (ms_reg == `TCC_MS_COMPARE);
            wire m_epw = ~center_align_select & ms_reg[1];
            wire m_cpw = center_align_select;
            wire rise  = chan_in[g] & ~pin_prev_reg;
            wire fall  = ~chan_in[g] & pin_prev_reg;
            wire cap_evt = m_cap & ((els_reg[0] & rise) | (els_reg[1] & fall));
            wire match   = cnt_tick & (cnt_val == val_reg);
            wire evt     = cap_evt | (~m_cap & match);
            wire paired  = hi_seen_reg & lo_seen_reg;
            // pwm channels hold new duty until a period boundary
            wire v_load  = paired & ~m_cap &
                           (m_cmp | (m_epw & (cnt_val == `TCC_ZERO_WORD)) |
                            (m_cpw & cnt_ovf));
            wire [15:0] rd_word = rlat_reg ? snap_reg : val_reg;
            wire        rd_hi   = rd & vhi_a;
            wire        rd_lo   = rd & vlo_a;
            wire        act     = ~els_reg[0];

            assign ch_rd_flat[8*g+7:8*g] =
                ctrl_a ? {flag_reg, ie_reg, ms_reg, els_reg, 2'b00} :
                (vhi_a | vlo_a) ? byte_sel(rd_word, vhi_a) : `TCC_RST_BYTE;
            assign chan_out[g] = out_reg;
            assign chan_oe[g]  = oe_reg;
            assign chan_irq[g] = irq_reg;

            always @*
            begin
                out_next = out_reg;
                if (m_cmp && match)
                begin
                    case (els_reg)
                        `TCC_ELS_TOGGLE: out_next = ~out_reg;
                        `TCC_ELS_CLEAR:  out_next = 1'b0;
                        `TCC_ELS_SET:    out_next = 1'b1;
                        default:         out_next = out_reg;
                    endcase
                end
                else if (m_epw)
                begin
                    // match is checked last so a zero value wins over the wrap
                    if (cnt_ovf)
                        out_next = act;
                    if (match)
                        out_next = ~act;
                end
                else if (m_cpw)
                begin
                    if (val_reg == `TCC_ZERO_WORD || val_reg[15])
                        out_next = ~act;
                    else if (val_reg > mod_value && mod_value != `TCC_ZERO_WORD)
                        out_next = act;
                    else if (match)
                        out_next = cnt_down ? act : ~act;
                end
            end

            always @(posedge clk)
            begin
                if (rst)
                begin
                    flag_reg      <= 1'b0;
                    arm_reg       <= 1'b0;
                    ie_reg        <= 1'b0;
                    ms_reg        <= `TCC_MS_CAPTURE;
                    els_reg       <= `TCC_ELS_OFF;
                    val_reg       <= `TCC_RST_WORD;
                    buf_reg       <= `TCC_RST_WORD;
                    hi_seen_reg   <= 1'b0;
                    lo_seen_reg   <= 1'b0;
                    snap_reg      <= `TCC_RST_WORD;
                    rlat_reg      <= 1'b0;
                    rfirst_hi_reg <= 1'b0;
                    pin_prev_reg  <= 1'b0;
                    out_reg       <= 1'b0;
                    oe_reg        <= 1'b0;
                    irq_reg       <= 1'b0;
                end
                else
                begin
                    pin_prev_reg <= chan_in[g];
                    if (evt)
                    begin
                        flag_reg <= 1'b1;
                        arm_reg  <= 1'b0;
                    end
                    else if (ctrl_wr && !wdat[`TCC_BIT_FLAG] && arm_reg)
                    begin
                        flag_reg <= 1'b0;
                        arm_reg  <= 1'b0;
                    end
                    else if (rd && ctrl_a && flag_reg)
                        arm_reg <= 1'b1;

                    if (ctrl_wr)
                    begin
                        ie_reg      <= wdat[`TCC_BIT_IE];
                        ms_reg      <= wdat[`TCC_BIT_MSB:`TCC_BIT_MSA];
                        els_reg     <= wdat[`TCC_BIT_ELSB:`TCC_BIT_ELSA];
                        hi_seen_reg <= 1'b0;
                        lo_seen_reg <= 1'b0;
                    end
                    else if (v_load)
                    begin
                        val_reg     <= buf_reg;
                        hi_seen_reg <= 1'b0;
                        lo_seen_reg <= 1'b0;
                    end
                    else if (wr && vhi_a)
                    begin
                        buf_reg[15:8] <= wdat;
                        hi_seen_reg   <= 1'b1;
                    end
                    else if (wr && vlo_a)
                    begin
                        buf_reg[7:0] <= wdat;
                        lo_seen_reg  <= 1'b1;
                    end
                    // capture overrides a pending load in the same cycle
                    if (cap_evt)
                        val_reg <= cnt_val;

                    if (ctrl_wr)
                        rlat_reg <= 1'b0;
                    else if ((rd_hi || rd_lo) && !rlat_reg)
                    begin
                        snap_reg      <= val_reg;
                        rlat_reg      <= 1'b1;
                        rfirst_hi_reg <= rd_hi;
                    end
                    else if ((rd_hi && !rfirst_hi_reg) || (rd_lo && rfirst_hi_reg))
                        rlat_reg <= 1'b0;

                    out_reg <= out_next;
                    oe_reg  <= ~m_cap & (els_reg != `TCC_ELS_OFF);
                    irq_reg <= flag_reg & ie_reg;
                end
            end
        end
    endgenerate

// ----------------------------------------------------------------------
// read data and acknowledge
// ----------------------------------------------------------------------
    reg [7:0] rd_byte;
    integer   k;

    always @*
    begin
        rd_byte = `TCC_RST_BYTE;
        if (mctrl_a)
            rd_byte = {ovf_flag_reg, ovf_ie_reg, center_align_select, misc_reg};
        else if (modhi_a)
            rd_byte = mod_value[15:8];
        else if (modlo_a)
            rd_byte = mod_value[7:0];
        for (k = 0; k < NCH; k = k + 1)
            if (ch_hit(wb_adr_i, k))
                rd_byte = ch_rd_flat[8*k +: 8];
    end

    // unmapped addresses ack with zero data and drop writes
    always @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= {`TCC_RD_PAD, `TCC_RST_BYTE};
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= {`TCC_RD_PAD, (rd ? rd_byte : `TCC_RST_BYTE)};
        end
    end

endmodule // tcc_channels
